// *** verilog/t1dl_top.sv ***
// t1 facility data link: code word, fifo port, legacy link shifters, axi4-lite registers
// Overview of operation
// RULE_01: underrun flag sticky, cleared by reading it
// RULE_02: rising trigger bit sends code word instead
// RULE_03: select 0 takes pin, 1 takes controller
// RULE_04: code word goes out bit 0 first
// RULE_05: fifo port write is one packet byte
// RULE_06: receivers concurrent, one transmit source only
// RULE_07: received bits shift in lsb first, eight
// RULE_08: full byte sets flag, masked interrupt low
// RULE_09: host reads each byte within 2 ms
// RULE_10: byte equal to match register sets flag
// RULE_11: destuffer deletes zero after five ones
// RULE_12: zero after six or more ones kept
// RULE_13: host keeps destuffing enabled while extracting
// RULE_14: esf uses link slots, d4 uses fs
// RULE_15: written byte serialised lsb first
// RULE_16: eight bits sent sets empty flag, interrupt
// RULE_17: host refills transmit byte within 2 ms
// RULE_18: no new byte means resend old byte
// RULE_19: stuffer inserts zero after five ones
// RULE_20: fifo underrun sets flag, abort follows
// RULE_21: multiframe mode loads only on boundaries
// RULE_22: ones count restarts after any zero
// RULE_23: match compare once per completed byte
//
// Chosen here: register access over AXI4-Lite.
module t1dl_top (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // framer timing and received bits
   input  wire logic        tx_fdl_slot,
   input  wire logic        tx_fs_slot,
   input  wire logic        tx_multiframe_start,
   input  wire logic        rx_fdl_slot,
   input  wire logic        rx_fs_slot,
   input  wire logic        rx_line_bit,
   // external link pin
   input  wire logic        ext_link_input,
   // hdlc controller side
   input  wire logic        hdlc_tx_bit,
   input  wire logic        hdlc_underrun,
   output logic [7:0]       hdlc_fifo_data,
   output logic             hdlc_fifo_wr,
   output logic             hdlc_bit_take,
   // outgoing link bit
   output logic             tx_link_bit,
   output logic             tx_link_strobe,
   // interrupt
   output logic             int_n
);
   logic [7:0]  tx_code_control, ctrl, mask, rx_match_byte_a, rx_match_byte_b, tx_link_byte, rx_link_byte;
   logic [7:0]  next_tx_code_control, next_ctrl, next_mask, next_match_a, next_match_b, next_tx_link_byte;
   logic [7:0]  next_rx_link_byte, next_fifo_data, status_vec, udr_vec;
   logic        rx_byte_full_flag, tx_byte_empty_flag, rx_match_flag, underrun_flag;
   logic        next_rx_full, next_tx_empty, next_match, next_underrun, next_fifo_wr, next_int_n;
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic        wr_go, rd_go, trig_rise, clr_status, clr_udr;
   logic [7:0]  aw_idx, ar_idx;
   logic        ext_meta, ext_sync;
   // transmit path state
   t1dl_pkg::t1dl_code_e code_state, next_code_state;
   logic [2:0]  code_idx, next_code_idx, tx_cnt, next_tx_cnt, tx_ones, next_tx_ones;
   logic [7:0]  tx_shift, next_tx_shift;
   logic        next_tx_bit, next_tx_strobe, next_take, tx_slot, tx_done, leg_bit;
   // receive path state
   logic [7:0]  rx_shift, next_rx_shift;
   logic [2:0]  rx_cnt, next_rx_cnt, rx_ones, next_rx_ones;
   logic        rx_slot, rx_done;

   assign aw_idx        = s_axi_awaddr[9:2];
   assign ar_idx        = s_axi_araddr[9:2];
   // address and data taken together; response only after both
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign trig_rise     = wr_go & s_axi_wstrb[0] & (aw_idx == t1dl_pkg::IDX_CODE_CTRL)
      & s_axi_wdata[t1dl_pkg::CODE_TRIG_BIT] & ~tx_code_control[t1dl_pkg::CODE_TRIG_BIT]; // [RULE_02]
   assign clr_status    = rd_go & (ar_idx == t1dl_pkg::IDX_STATUS);
   assign clr_udr       = rd_go & (ar_idx == t1dl_pkg::IDX_TX_STAT);
   assign tx_slot       = ctrl[t1dl_pkg::CTRL_ESF_BIT] ? tx_fdl_slot : tx_fs_slot; // [RULE_14]
   assign rx_slot       = ctrl[t1dl_pkg::CTRL_ESF_BIT] ? rx_fdl_slot : rx_fs_slot; // [RULE_14]

   always_comb begin
      status_vec = t1dl_pkg::REG_RST;
      status_vec[t1dl_pkg::ST_RXFULL_BIT] = rx_byte_full_flag;
      status_vec[t1dl_pkg::ST_TXEMPTY_BIT] = tx_byte_empty_flag;
      status_vec[t1dl_pkg::ST_MATCH_BIT] = rx_match_flag;
      udr_vec = t1dl_pkg::REG_RST;
      udr_vec[t1dl_pkg::UDR_BIT] = underrun_flag;
   end

   // register file and bus answers
   always_comb begin
      next_tx_code_control = tx_code_control;
      next_ctrl            = ctrl;
      next_mask            = mask;
      next_match_a         = rx_match_byte_a;
      next_match_b         = rx_match_byte_b;
      next_tx_link_byte    = tx_link_byte;
      next_fifo_data       = hdlc_fifo_data;
      next_fifo_wr         = 1'b0;
      next_bvalid          = s_axi_bvalid & ~s_axi_bready;
      next_bresp           = s_axi_bresp;
      next_rvalid          = s_axi_rvalid & ~s_axi_rready;
      next_rresp           = s_axi_rresp;
      next_rdata           = s_axi_rdata;
      if (wr_go) begin
         next_bvalid = 1'b1;
         next_bresp  = t1dl_pkg::RESP_OKAY;
         case (aw_idx)
            t1dl_pkg::IDX_CODE_CTRL: if (s_axi_wstrb[0]) next_tx_code_control = s_axi_wdata[7:0];
            t1dl_pkg::IDX_TX_FIFO: begin
               if (s_axi_wstrb[0]) begin
                  next_fifo_data = s_axi_wdata[7:0]; // [RULE_05]
                  next_fifo_wr   = 1'b1;
               end
            end
            t1dl_pkg::IDX_MATCH_A:   if (s_axi_wstrb[0]) next_match_a = s_axi_wdata[7:0];
            t1dl_pkg::IDX_MATCH_B:   if (s_axi_wstrb[0]) next_match_b = s_axi_wdata[7:0];
            t1dl_pkg::IDX_CTRL:      if (s_axi_wstrb[0]) next_ctrl = s_axi_wdata[7:0];
            t1dl_pkg::IDX_MASK:      if (s_axi_wstrb[0]) next_mask = s_axi_wdata[7:0];
            t1dl_pkg::IDX_TX_LINK:   if (s_axi_wstrb[0]) next_tx_link_byte = s_axi_wdata[7:0];
            // read-only registers ignore writes quietly
            t1dl_pkg::IDX_RX_LINK, t1dl_pkg::IDX_STATUS, t1dl_pkg::IDX_TX_STAT: next_bresp = t1dl_pkg::RESP_OKAY;
            default:                 next_bresp = t1dl_pkg::RESP_SLVERR;
         endcase
      end
      if (rd_go) begin
         next_rvalid = 1'b1;
         next_rresp  = t1dl_pkg::RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         case (ar_idx)
            t1dl_pkg::IDX_CODE_CTRL: next_rdata[7:0] = tx_code_control;
            t1dl_pkg::IDX_TX_FIFO:   next_rdata[7:0] = t1dl_pkg::REG_RST;
            t1dl_pkg::IDX_RX_LINK:   next_rdata[7:0] = rx_link_byte;
            t1dl_pkg::IDX_MATCH_A:   next_rdata[7:0] = rx_match_byte_a;
            t1dl_pkg::IDX_MATCH_B:   next_rdata[7:0] = rx_match_byte_b;
            t1dl_pkg::IDX_CTRL:      next_rdata[7:0] = ctrl;
            t1dl_pkg::IDX_STATUS:    next_rdata[7:0] = status_vec;
            t1dl_pkg::IDX_MASK:      next_rdata[7:0] = mask;
            t1dl_pkg::IDX_TX_LINK:   next_rdata[7:0] = tx_link_byte;
            t1dl_pkg::IDX_TX_STAT:   next_rdata[7:0] = udr_vec;
            default:                 next_rresp = t1dl_pkg::RESP_SLVERR;
         endcase
      end
      // set wins over the clear of a read in the same cycle
      next_rx_full  = (rx_byte_full_flag & ~clr_status) | rx_done; // [RULE_08]
      next_tx_empty = (tx_byte_empty_flag & ~clr_status) | tx_done; // [RULE_16]
      next_match    = (rx_match_flag & ~clr_status)
                      | (rx_done & ((next_rx_link_byte == rx_match_byte_a)
                      | (next_rx_link_byte == rx_match_byte_b))); // [RULE_10] [RULE_23]
      next_underrun = (underrun_flag & ~clr_udr) | hdlc_underrun; // [RULE_01] [RULE_20]
      next_int_n    = ~|(status_vec & mask); // [RULE_08] [RULE_10] [RULE_16]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_code_control    <= t1dl_pkg::REG_RST;
         ctrl               <= t1dl_pkg::REG_RST;
         mask               <= t1dl_pkg::REG_RST;
         rx_match_byte_a    <= t1dl_pkg::REG_RST;
         rx_match_byte_b    <= t1dl_pkg::REG_RST;
         tx_link_byte       <= t1dl_pkg::REG_RST;
         hdlc_fifo_data     <= t1dl_pkg::REG_RST;
         hdlc_fifo_wr       <= 1'b0;
         s_axi_bvalid       <= 1'b0;
         s_axi_bresp        <= t1dl_pkg::RESP_OKAY;
         s_axi_rvalid       <= 1'b0;
         s_axi_rresp        <= t1dl_pkg::RESP_OKAY;
         s_axi_rdata        <= 32'h0000_0000;
         rx_byte_full_flag  <= 1'b0;
         tx_byte_empty_flag <= 1'b0;
         rx_match_flag      <= 1'b0;
         underrun_flag      <= 1'b0;
         int_n              <= 1'b1;
      end else begin
         tx_code_control    <= next_tx_code_control;
         ctrl               <= next_ctrl;
         mask               <= next_mask;
         rx_match_byte_a    <= next_match_a;
         rx_match_byte_b    <= next_match_b;
         tx_link_byte       <= next_tx_link_byte;
         hdlc_fifo_data     <= next_fifo_data;
         hdlc_fifo_wr       <= next_fifo_wr;
         s_axi_bvalid       <= next_bvalid;
         s_axi_bresp        <= next_bresp;
         s_axi_rvalid       <= next_rvalid;
         s_axi_rresp        <= next_rresp;
         s_axi_rdata        <= next_rdata;
         rx_byte_full_flag  <= next_rx_full;
         tx_byte_empty_flag <= next_tx_empty;
         rx_match_flag      <= next_match;
         underrun_flag      <= next_underrun;
         int_n              <= next_int_n;
      end
   end

   // pin is asynchronous to aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
      end else begin
         ext_meta <= ext_link_input;
         ext_sync <= ext_meta;
      end
   end

   // transmit: code word sender, legacy shifter with stuffer, source mux
   always_comb begin
      next_code_state = code_state;
      next_code_idx   = code_idx;
      next_tx_shift   = tx_shift;
      next_tx_cnt     = tx_cnt;
      next_tx_ones    = tx_ones;
      next_tx_bit     = tx_link_bit;
      next_tx_strobe  = 1'b0;
      next_take       = 1'b0;
      tx_done         = 1'b0;
      leg_bit         = 1'b0;
      // mf mode: reload waits for the boundary, the old byte rotates until then
      if (ctrl[t1dl_pkg::CTRL_MFLOAD_BIT] && tx_multiframe_start) begin
         next_tx_shift = tx_link_byte; // [RULE_21]
         next_tx_cnt   = 3'h0;
      end else if (tx_slot) begin
         if (ctrl[t1dl_pkg::CTRL_STUFF_BIT] && tx_ones == t1dl_pkg::ONES_RUN) begin
            leg_bit      = 1'b0; // [RULE_19]
            next_tx_ones = 3'h0; // [RULE_22]
         end else begin
            leg_bit       = tx_shift[0]; // [RULE_15]
            next_tx_ones  = tx_shift[0] ? ((tx_ones == t1dl_pkg::ONES_MAX) ? tx_ones : tx_ones + 3'h1) : 3'h0;
            next_tx_shift = {tx_shift[0], tx_shift[7:1]}; // [RULE_18]
            next_tx_cnt   = tx_cnt + 3'h1;
            if (tx_cnt == t1dl_pkg::BYTE_LAST) begin
               tx_done = 1'b1; // [RULE_16]
               if (!ctrl[t1dl_pkg::CTRL_MFLOAD_BIT]) next_tx_shift = tx_link_byte; // [RULE_15]
            end
         end
      end
      if (tx_slot && !(ctrl[t1dl_pkg::CTRL_MFLOAD_BIT] && tx_multiframe_start)) begin
         next_tx_strobe = 1'b1;
         // a single source feeds the outgoing link bit
         if (tx_code_control[t1dl_pkg::CODE_SRC_BIT]) begin // [RULE_03] [RULE_06]
            if (code_state == t1dl_pkg::CODE_SEND) begin
               next_tx_bit = tx_code_control[code_idx]; // [RULE_04]
               next_code_idx = code_idx + 3'h1;
               if (code_idx == t1dl_pkg::CODE_LAST) next_code_state = t1dl_pkg::CODE_IDLE;
            end else begin
               next_tx_bit = hdlc_tx_bit;
               next_take   = 1'b1;
            end
         end else if (ctrl[t1dl_pkg::CTRL_LEGACY_BIT]) begin
            next_tx_bit = leg_bit; // [RULE_06]
         end else begin
            next_tx_bit = ext_sync; // [RULE_03]
         end
      end
      // last so a fresh trigger restarts the word even while one is going out
      if (trig_rise) begin
         next_code_state = t1dl_pkg::CODE_SEND; // [RULE_02]
         next_code_idx   = 3'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_state     <= t1dl_pkg::CODE_IDLE;
         code_idx       <= 3'h0;
         tx_shift       <= t1dl_pkg::REG_RST;
         tx_cnt         <= 3'h0;
         tx_ones        <= 3'h0;
         tx_link_bit    <= 1'b0;
         tx_link_strobe <= 1'b0;
         hdlc_bit_take  <= 1'b0;
      end else begin
         code_state     <= next_code_state;
         code_idx       <= next_code_idx;
         tx_shift       <= next_tx_shift;
         tx_cnt         <= next_tx_cnt;
         tx_ones        <= next_tx_ones;
         tx_link_bit    <= next_tx_bit;
         tx_link_strobe <= next_tx_strobe;
         hdlc_bit_take  <= next_take;
      end
   end

   // receive: destuffer and byte assembler, runs beside the hdlc receiver
   always_comb begin
      next_rx_shift     = rx_shift;
      next_rx_cnt       = rx_cnt;
      next_rx_ones      = rx_ones;
      next_rx_link_byte = rx_link_byte;
      rx_done           = 1'b0;
      if (rx_slot) begin
         if (rx_line_bit) begin
            next_rx_ones = (rx_ones == t1dl_pkg::ONES_MAX) ? rx_ones : rx_ones + 3'h1;
         end else begin
            next_rx_ones = 3'h0; // [RULE_22]
         end
         // only a run of exactly five is destuffed; six or more keep the zero
         if (!(ctrl[t1dl_pkg::CTRL_DESTUFF_BIT] && !rx_line_bit && rx_ones == t1dl_pkg::ONES_RUN)) begin
            next_rx_shift = {rx_line_bit, rx_shift[7:1]}; // [RULE_07] [RULE_11] [RULE_12]
            next_rx_cnt   = rx_cnt + 3'h1;
            if (rx_cnt == t1dl_pkg::BYTE_LAST) begin
               rx_done           = 1'b1; // [RULE_07]
               next_rx_link_byte = {rx_line_bit, rx_shift[7:1]};
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_shift     <= t1dl_pkg::REG_RST;
         rx_cnt       <= 3'h0;
         rx_ones      <= 3'h0;
         rx_link_byte <= t1dl_pkg::REG_RST;
      end else begin
         rx_shift     <= next_rx_shift;
         rx_cnt       <= next_rx_cnt;
         rx_ones      <= next_rx_ones;
         rx_link_byte <= next_rx_link_byte;
      end
   end

   a_udr_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
      underrun_flag && !clr_udr |=> underrun_flag) else $error("underrun flag dropped without read");
   a_code_start: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
      trig_rise |=> code_state == t1dl_pkg::CODE_SEND && code_idx == 3'h0) else $error("code word not started");
   a_src_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
      tx_slot && !tx_multiframe_start && !tx_code_control[t1dl_pkg::CODE_SRC_BIT] && !ctrl[t1dl_pkg::CTRL_LEGACY_BIT]
      |=> tx_link_strobe && tx_link_bit == $past(ext_sync) && !hdlc_bit_take) else $error("pin not sourced");
   a_code_order: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
      tx_slot && !tx_multiframe_start && tx_code_control[t1dl_pkg::CODE_SRC_BIT]
      && code_state == t1dl_pkg::CODE_SEND && code_idx == 3'h0 && !trig_rise
      |=> tx_link_bit == $past(tx_code_control[0])) else $error("code bit 0 not first");
   a_fifo_byte: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
      wr_go && s_axi_wstrb[0] && aw_idx == t1dl_pkg::IDX_TX_FIFO
      |=> hdlc_fifo_wr && hdlc_fifo_data == $past(s_axi_wdata[7:0])) else $error("fifo byte lost");
   a_rx_fill: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
      rx_done |=> rx_byte_full_flag && rx_link_byte[7] == $past(rx_line_bit)) else $error("receive byte not posted");
   a_int_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
      |(status_vec & mask) |=> !int_n) else $error("enabled event left interrupt high");
   a_destuff: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
      rx_slot && ctrl[t1dl_pkg::CTRL_DESTUFF_BIT] && !rx_line_bit && rx_ones == t1dl_pkg::ONES_RUN
      |=> rx_cnt == $past(rx_cnt) && rx_ones == 3'h0) else $error("stuffed zero kept");
   a_keep_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
      rx_slot && !rx_line_bit && rx_ones > t1dl_pkg::ONES_RUN
      |=> rx_cnt != $past(rx_cnt)) else $error("zero after long run removed");
   a_tx_stuff: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_19]
      tx_slot && !tx_multiframe_start && ctrl[t1dl_pkg::CTRL_STUFF_BIT] && tx_ones == t1dl_pkg::ONES_RUN
      |=> tx_ones == 3'h0 && tx_cnt == $past(tx_cnt)) else $error("zero not inserted");
   a_tx_empty: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_16]
      tx_done ##1 1'b1 |-> tx_byte_empty_flag) else $error("empty flag not set");
endmodule : t1dl_top

// *** verilog/t1dl_pkg.sv ***
// register map, field positions and reset values of the t1 data link block
package t1dl_pkg;
   // bus geometry; byte address is four times the register index
   localparam int         ADDR_W          = 10;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   // register indices
   localparam logic [7:0] IDX_CODE_CTRL   = 8'h07;
   localparam logic [7:0] IDX_TX_FIFO     = 8'h08;
   localparam logic [7:0] IDX_RX_LINK     = 8'h28;
   localparam logic [7:0] IDX_MATCH_A     = 8'h29;
   localparam logic [7:0] IDX_MATCH_B     = 8'h2A;
   localparam logic [7:0] IDX_CTRL        = 8'h30;
   localparam logic [7:0] IDX_STATUS      = 8'h31;
   localparam logic [7:0] IDX_MASK        = 8'h32;
   localparam logic [7:0] IDX_TX_LINK     = 8'h33;
   localparam logic [7:0] IDX_TX_STAT     = 8'h34;

   // tx_code_control fields
   localparam int         CODE_TRIG_BIT   = 7;
   localparam int         CODE_SRC_BIT    = 6;
   localparam logic [2:0] CODE_LAST       = 3'h5;

   // control register fields
   localparam int         CTRL_DESTUFF_BIT = 0;
   localparam int         CTRL_ESF_BIT     = 1;
   localparam int         CTRL_LEGACY_BIT  = 2;
   localparam int         CTRL_STUFF_BIT   = 4;
   localparam int         CTRL_MFLOAD_BIT  = 5;

   // status and mask fields, underrun field
   localparam int         ST_MATCH_BIT    = 2;
   localparam int         ST_TXEMPTY_BIT  = 3;
   localparam int         ST_RXFULL_BIT   = 4;
   localparam int         UDR_BIT         = 0;

   // reset values
   localparam logic [7:0] REG_RST         = 8'h00;

   // stuffing and byte counts
   localparam logic [2:0] ONES_RUN        = 3'h5;
   localparam logic [2:0] ONES_MAX        = 3'h7;
   localparam logic [2:0] BYTE_LAST       = 3'h7;

   typedef enum logic {
      CODE_IDLE = 1'b0,
      CODE_SEND = 1'b1
   } t1dl_code_e;
endpackage : t1dl_pkg

// *** tb/t1dl_line_model.sv ***
// framer-side model: link slot timing and received link bits
module t1dl_line_model (
   // clock
   input  wire logic aclk,
   // slot pulses and received bit
   output logic      tx_fdl_slot,
   output logic      rx_fdl_slot,
   output logic      rx_line_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial begin
      rx_fdl_slot = 1'b0;
      rx_line_bit = 1'b0;
   end
   // one slot every 16 clocks stands in for one frame, to keep the run short
   always @(posedge aclk) begin
      cnt <= (cnt + 1) % 16;
      tx_fdl_slot <= (cnt == 15);
   end
   // the bit means nothing away from its slot, so it is inverted there
   task automatic rx_bit(input logic b);
      @(posedge aclk);
      rx_fdl_slot <= 1'b1;
      rx_line_bit <= b;
      @(posedge aclk);
      rx_fdl_slot <= 1'b0;
      rx_line_bit <= ~b;
      repeat (3) @(posedge aclk);
   endtask : rx_bit
endmodule : t1dl_line_model

// *** tb/t1_data_link_insert_extract_test.sv ***
// self-checking bench for the t1 data link block
module t1_data_link_insert_extract_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        tx_fdl_slot, rx_fdl_slot, rx_line_bit, ext_link_input, hdlc_tx_bit, hdlc_underrun, e;
   logic        tx_fs_slot = 1'b0, tx_multiframe_start = 1'b0, rx_fs_slot = 1'b0;
   logic [7:0]  hdlc_fifo_data, fifo_seen, ma, mb, kept, x;
   logic        hdlc_fifo_wr, hdlc_bit_take, tx_link_bit, tx_link_strobe, int_n;
   logic [15:0] v;
   logic [5:0]  code;
   int          bad_count = 0, check_count = 0, ones = 0, nk = 0, z;
   bit          destuff = 1'b0;

   t1dl_top i_dut (.*);
   t1dl_line_model i_line (.aclk(aclk), .tx_fdl_slot(tx_fdl_slot), .rx_fdl_slot(rx_fdl_slot),
                           .rx_line_bit(rx_line_bit));

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) hdlc_tx_bit <= 1'($urandom);
   // the fifo write pulse lasts one cycle and rises in the same cycle as the bus response
   always @(negedge aclk) if (hdlc_fifo_wr === 1'b1) fifo_seen = hdlc_fifo_data;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         bad_count++;
      end
   endtask : chk

   task automatic finish_test;
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, dat};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(negedge aclk); while (s_axi_awready !== 1'b1);
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [31:0] dat);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      dat = s_axi_rdata;
      chk(s_axi_rresp, t1dl_pkg::RESP_OKAY);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic get_bits(input int n);
      for (int i = 0; i < n; i++) begin
         do @(negedge aclk); while (tx_link_strobe !== 1'b1);
         v[i] = tx_link_bit;
      end
   endtask : get_bits

   task automatic rx_send(input logic b);
      i_line.rx_bit(b);
      if (destuff && ones == 5 && !b) begin
         ones = 0;
         return;
      end
      ones = b ? ones + 1 : 0;
      kept = {b, kept[7:1]};
      nk++;
      if (nk % 8 == 0) begin
         chk(int_n, 1'b0);
         rd(t1dl_pkg::IDX_RX_LINK, d);
         chk(d, {24'h0, kept});
         rd(t1dl_pkg::IDX_STATUS, d);
         chk(d & 32'h14, {27'h0, 1'b1, 1'b0, kept == ma || kept == mb, 2'h0});
      end
   endtask : rx_send

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {ext_link_input, hdlc_underrun} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'hD8BB867C));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      ma = 8'($urandom) & 8'h7F;
      mb = 8'($urandom);
      wr(t1dl_pkg::IDX_MATCH_A, ma);
      wr(t1dl_pkg::IDX_MATCH_B, mb);
      rd(t1dl_pkg::IDX_MATCH_A, d);
      chk(d, {24'h0, ma});
      wr(8'h3F, 8'h55);
      chk(rsp, t1dl_pkg::RESP_SLVERR);
      wr(t1dl_pkg::IDX_MASK, 8'h14);
      wr(t1dl_pkg::IDX_CTRL, 8'h02);
      for (int i = 0; i < 8; i++) rx_send(ma[i]);
      // host keeps destuffing on while extracting
      wr(t1dl_pkg::IDX_CTRL, 8'h03);
      destuff = 1'b1;
      for (int i = 0; nk < 24; i++) rx_send(i < 13 ? 1'((16'h0FDF >> i) & 1) : 1'($urandom));
      code = 6'($urandom);
      e = 1'($urandom);
      wr(t1dl_pkg::IDX_CODE_CTRL, {2'b00, code});
      ext_link_input <= e;
      get_bits(2);
      get_bits(2);
      chk(v[1:0], {e, e});
      get_bits(1);
      wr(t1dl_pkg::IDX_CODE_CTRL, {2'b11, code});
      get_bits(6);
      chk(v[5:0], code);
      x = 8'($urandom);
      wr(t1dl_pkg::IDX_TX_FIFO, x);
      chk(fifo_seen, x);
      // the legacy shifter only reaches the link while the controller is deselected
      wr(t1dl_pkg::IDX_CODE_CTRL, {2'b00, code});
      wr(t1dl_pkg::IDX_CTRL, 8'h07);
      wr(t1dl_pkg::IDX_MASK, 8'h08);
      wr(t1dl_pkg::IDX_TX_LINK, x);
      rd(t1dl_pkg::IDX_STATUS, d);
      do @(negedge aclk); while (int_n !== 1'b0);
      rd(t1dl_pkg::IDX_STATUS, d);
      chk(d[3], 1'b1);
      get_bits(16);
      chk(v, {x, x});
      wr(t1dl_pkg::IDX_CTRL, 8'h17);
      wr(t1dl_pkg::IDX_TX_LINK, 8'hFF);
      get_bits(16);
      get_bits(14);
      z = 0;
      while (z < 5 && v[z]) z++;
      for (int j = z; j < 14; j++) chk(v[j], (j - z) % 6 != 0);
      // multiframe load: the new byte waits for the boundary pulse
      wr(t1dl_pkg::IDX_CTRL, 8'h27);
      wr(t1dl_pkg::IDX_TX_LINK, x & 8'h7F);
      get_bits(8);
      chk(v[7:0], 8'hFF);
      @(posedge aclk);
      tx_multiframe_start <= 1'b1;
      @(posedge aclk);
      tx_multiframe_start <= 1'b0;
      get_bits(8);
      chk(v[7:0], x & 8'h7F);
      // d4 mode: the fs slot carries the next bit of the rotating byte
      wr(t1dl_pkg::IDX_CTRL, 8'h25);
      @(posedge aclk);
      tx_fs_slot <= 1'b1;
      @(posedge aclk);
      tx_fs_slot <= 1'b0;
      @(negedge aclk);
      chk({tx_link_strobe, tx_link_bit}, {1'b1, x[0]});
      @(posedge aclk);
      hdlc_underrun <= 1'b1;
      @(posedge aclk);
      hdlc_underrun <= 1'b0;
      rd(t1dl_pkg::IDX_TX_STAT, d);
      chk(d[0], 1'b1);
      rd(t1dl_pkg::IDX_TX_STAT, d);
      chk(d[0], 1'b0);
      finish_test();
   end

   initial begin
      #500_000;
      bad_count++;
      finish_test();
   end
endmodule : t1_data_link_insert_extract_test
